// *** hdl/hucia_device.sv ***
// Hash unit control, status, input staging and interrupt logic
module hucia_device
    import hucia_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    hucia_if.device bus,
    output logic busy_o,
    output logic [31:0] digest_sum_o
);
    logic algo_hi_r, long_key_r, multi_dma_r, algo_lo_r, keyed_mode_r;
    logic dma_en_r;
    logic [1:0] swap_mode_r;
    logic [4:0] valid_bits_r;
    logic [1:0] inten_r;
    logic input_done_r, calc_done_r;
    logic word_pending_r;
    logic [3:0] fifo_count_r;
    logic [31:0] di_r;
    logic [31:0] sum_r;
    logic busy_r, final_r, auto_final_r, dma_active_r;
    logic [7:0] proc_cnt_r;
    logic ack_r;
    logic [31:0] rdata_r;

    function automatic logic [31:0] swap_word(input logic [1:0] mode,
                                              input logic [31:0] w);
        logic [31:0] r;
        r = w;
        case (mode)
            2'b01: r = {w[15:0], w[31:16]};
            2'b10: r = {w[7:0], w[15:8], w[23:16], w[31:24]};
            2'b11: begin
                for (int i = 0; i < 32; i++) begin
                    r[i] = w[31-i];
                end
            end
            default: r = w;
        endcase
        return r;
    endfunction : swap_word

    function automatic logic [7:0] algo_cycles(input logic [1:0] a);
        logic [7:0] c;
        case (hucia_algo_t'(a))
            HUC_SHA1: c = SHA1_CYCLES;
            HUC_MD5: c = MD5_CYCLES;
            default: c = SHA2_CYCLES;
        endcase
        return c;
    endfunction : algo_cycles

    logic [1:0] algo;
    logic stall, take, wr, rd;
    logic ctl_wr, di_wr, cfg_wr, inten_wr, stat_wr;
    logic start_wr, final_wr, do_final, block_full, proc_done;
    logic [31:0] ctl_view, stat_view;

    assign algo = {algo_hi_r, algo_lo_r};
    // Input writes wait while the core is working
    assign stall = (busy_r || auto_final_r) && bus.we &&
                   (bus.addr == HUC_DI_OFS || bus.addr == HUC_CFG_OFS);
    assign take = bus.req && !ack_r && !stall;
    assign wr = take && bus.we;
    assign rd = take && !bus.we;
    assign ctl_wr = wr && bus.addr == HUC_CTL_OFS;
    assign di_wr = wr && bus.addr == HUC_DI_OFS;
    assign cfg_wr = wr && bus.addr == HUC_CFG_OFS;
    assign inten_wr = wr && bus.addr == HUC_INTEN_OFS;
    assign stat_wr = wr && bus.addr == HUC_STAT_OFS;
    assign start_wr = ctl_wr && bus.wdata[CTL_START_B];
    assign final_wr = cfg_wr && bus.wdata[CFG_FINAL_B];
    assign do_final = final_wr || auto_final_r;
    assign block_full = di_wr && word_pending_r &&
                        fifo_count_r == BLOCK_LAST_WORD;
    assign proc_done = busy_r && proc_cnt_r == 8'h01;

    // Control fields written by software
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            algo_hi_r <= 1'b0;
            long_key_r <= 1'b0;
            multi_dma_r <= 1'b0;
            algo_lo_r <= 1'b0;
            keyed_mode_r <= 1'b0;
            swap_mode_r <= 2'b00;
        end else if (ctl_wr) begin
            algo_hi_r <= bus.wdata[CTL_ALGO_HI_B];
            long_key_r <= bus.wdata[CTL_LONG_KEY_B];
            multi_dma_r <= bus.wdata[CTL_MULTI_DMA_B];
            algo_lo_r <= bus.wdata[CTL_ALGO_LO_B];
            keyed_mode_r <= bus.wdata[CTL_KEYED_B];
            swap_mode_r <= bus.wdata[CTL_SWAP_LSB +: 2];
        end
    end

    // DMA enable and the transfer it launched
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dma_en_r <= 1'b0;
            dma_active_r <= 1'b0;
        end else begin
            if (di_wr && bus.last) begin
                dma_en_r <= 1'b0;
            end else if (ctl_wr) begin
                dma_en_r <= bus.wdata[CTL_DMA_EN_B];
            end
            if ((di_wr && bus.last) || start_wr) begin
                dma_active_r <= 1'b0;
            end else if (ctl_wr && bus.wdata[CTL_DMA_EN_B]) begin
                dma_active_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_bits_r <= 5'h00;
            inten_r <= 2'b00;
        end else begin
            if (cfg_wr) begin
                valid_bits_r <= bus.wdata[CFG_VALID_LSB +: 5];
            end
            if (inten_wr) begin
                inten_r <= bus.wdata[STAT_CALC_B:STAT_INPUT_B];
            end
        end
    end

    // Input staging: held word, pending bit, FIFO count, running sum
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            di_r <= HUC_RESET_VAL;
            word_pending_r <= 1'b0;
            fifo_count_r <= 4'h0;
            sum_r <= HUC_RESET_VAL;
        end else if (start_wr) begin
            word_pending_r <= 1'b0;
            fifo_count_r <= 4'h0;
            sum_r <= HUC_RESET_VAL;
        end else if (do_final) begin
            if (word_pending_r) begin
                sum_r <= sum_r ^ swap_word(swap_mode_r, di_r);
            end
            word_pending_r <= 1'b0;
            fifo_count_r <= 4'h0;
        end else if (di_wr) begin
            di_r <= bus.wdata;
            word_pending_r <= 1'b1;
            if (word_pending_r) begin
                sum_r <= sum_r ^ swap_word(swap_mode_r, di_r);
                fifo_count_r <= block_full ? 4'h0 :
                                fifo_count_r + 4'h1;
            end
        end
    end

    // Core timing stand-in: block or final run length by algorithm
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_r <= 1'b0;
            final_r <= 1'b0;
            auto_final_r <= 1'b0;
            proc_cnt_r <= 8'h00;
        end else begin
            auto_final_r <= di_wr && bus.last && !multi_dma_r;
            if (start_wr) begin
                busy_r <= 1'b0;
                final_r <= 1'b0;
                proc_cnt_r <= 8'h00;
            end else if (do_final || block_full) begin
                busy_r <= 1'b1;
                final_r <= do_final;
                proc_cnt_r <= algo_cycles(algo);
            end else if (busy_r) begin
                proc_cnt_r <= proc_cnt_r - 8'h01;
                if (proc_done) begin
                    busy_r <= 1'b0;
                end
            end
        end
    end

    // Flags: hardware set wins over software clear (write 0 clears)
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            input_done_r <= 1'b0;
            calc_done_r <= 1'b0;
        end else begin
            if (proc_done && !final_r) begin
                input_done_r <= 1'b1;
            end else if (stat_wr && !bus.wdata[STAT_INPUT_B]) begin
                input_done_r <= 1'b0;
            end
            if (proc_done && final_r) begin
                calc_done_r <= 1'b1;
            end else if (stat_wr && !bus.wdata[STAT_CALC_B]) begin
                calc_done_r <= 1'b0;
            end
        end
    end

    always_comb begin
        ctl_view = HUC_RESET_VAL;
        ctl_view[CTL_ALGO_HI_B] = algo_hi_r;
        ctl_view[CTL_LONG_KEY_B] = long_key_r;
        ctl_view[CTL_MULTI_DMA_B] = multi_dma_r;
        ctl_view[CTL_PENDING_B] = word_pending_r;
        ctl_view[CTL_COUNT_LSB +: 4] = fifo_count_r;
        ctl_view[CTL_ALGO_LO_B] = algo_lo_r;
        ctl_view[CTL_KEYED_B] = keyed_mode_r;
        ctl_view[CTL_SWAP_LSB +: 2] = swap_mode_r;
        ctl_view[CTL_DMA_EN_B] = dma_en_r;
        stat_view = HUC_RESET_VAL;
        stat_view[STAT_INPUT_B] = input_done_r;
        stat_view[STAT_CALC_B] = calc_done_r;
        stat_view[STAT_BUSY_B] = busy_r;
    end

    // Registered answer, one cycle after the request is taken
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_r <= 1'b0;
            rdata_r <= HUC_RESET_VAL;
        end else begin
            ack_r <= take;
            if (rd) begin
                case (bus.addr)
                    HUC_CTL_OFS: rdata_r <= ctl_view;
                    HUC_DI_OFS: rdata_r <= di_r;
                    HUC_CFG_OFS: rdata_r <= {27'h0, valid_bits_r};
                    HUC_SUM_OFS: rdata_r <= sum_r;
                    HUC_INTEN_OFS: rdata_r <= {30'h0, inten_r};
                    HUC_STAT_OFS: rdata_r <= stat_view;
                    default: rdata_r <= HUC_RESET_VAL;
                endcase
            end
        end
    end

    assign bus.ack = ack_r;
    assign bus.rdata = rdata_r;
    assign bus.dma_req = dma_active_r && !busy_r && !auto_final_r;
    assign bus.irq = (input_done_r && inten_r[0]) ||
                     (calc_done_r && inten_r[1]);
    assign busy_o = busy_r;
    assign digest_sum_o = sum_r;
endmodule : hucia_device

// *** hdl/hucia_pkg.sv ***
// Shared constants and types of the hash unit control block
package hucia_pkg;
    // Device register byte offsets
    localparam logic [7:0] HUC_CTL_OFS = 8'h00;
    localparam logic [7:0] HUC_DI_OFS = 8'h04;
    localparam logic [7:0] HUC_CFG_OFS = 8'h08;
    localparam logic [7:0] HUC_SUM_OFS = 8'h0C;
    localparam logic [7:0] HUC_INTEN_OFS = 8'h20;
    localparam logic [7:0] HUC_STAT_OFS = 8'h24;
    // Control register fields
    localparam int CTL_ALGO_HI_B = 18;
    localparam int CTL_LONG_KEY_B = 16;
    localparam int CTL_MULTI_DMA_B = 13;
    localparam int CTL_PENDING_B = 12;
    localparam int CTL_COUNT_LSB = 8;
    localparam int CTL_ALGO_LO_B = 7;
    localparam int CTL_KEYED_B = 6;
    localparam int CTL_SWAP_LSB = 4;
    localparam int CTL_DMA_EN_B = 3;
    localparam int CTL_START_B = 2;
    // Configuration register fields
    localparam int CFG_FINAL_B = 8;
    localparam int CFG_VALID_LSB = 0;
    // Status and enable fields
    localparam int STAT_INPUT_B = 0;
    localparam int STAT_CALC_B = 1;
    localparam int STAT_BUSY_B = 3;
    localparam logic [31:0] HUC_RESET_VAL = 32'h0000_0000;
    // Core cycles per block, per algorithm
    localparam logic [7:0] SHA1_CYCLES = 8'h50;
    localparam logic [7:0] MD5_CYCLES = 8'h40;
    localparam logic [7:0] SHA2_CYCLES = 8'h40;
    localparam logic [3:0] BLOCK_LAST_WORD = 4'hF;
    // Controller register byte offsets on AHB-Lite
    localparam logic [7:0] CTRL_CMD_OFS = 8'h00;
    localparam logic [7:0] CTRL_WDATA_OFS = 8'h04;
    localparam logic [7:0] CTRL_RDATA_OFS = 8'h08;
    localparam logic [7:0] CTRL_STATUS_OFS = 8'h0C;
    localparam logic [7:0] CTRL_DMA_OFS = 8'h10;
    localparam logic [7:0] CTRL_DMA_LAST_OFS = 8'h14;
    localparam int CMD_WRITE_B = 31;

    typedef enum logic [1:0] {
        HUC_SHA1 = 2'b00,
        HUC_MD5 = 2'b01,
        HUC_SHA224 = 2'b10,
        HUC_SHA256 = 2'b11
    } hucia_algo_t;
endpackage : hucia_pkg

// *** hdl/hucia_if.sv ***
// Link between the hash unit and its feeding controller
interface hucia_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic last;
    logic ack;
    logic [31:0] rdata;
    logic dma_req;
    logic irq;

    modport device (
        input req, we, addr, wdata, last,
        output ack, rdata, dma_req, irq
    );
    modport feeder (
        output req, we, addr, wdata, last,
        input ack, rdata, dma_req, irq
    );
endinterface : hucia_if

// *** hdl/hucia_feeder.sv ***
// AHB-Lite controller that drives the hash unit link for software
module hucia_feeder
    import hucia_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    hucia_if.feeder link,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic irq_o
);
    logic dp_valid_r, dp_write_r;
    logic [7:0] dp_addr_r;
    logic [31:0] wdata_r, rdata_r, hrdata_r;
    logic req_r, we_r, last_r;
    logic [7:0] addr_r;
    logic [31:0] lwdata_r;
    logic launch_r;

    logic dp_cmd, dp_dma, hold, launch;

    // Address phase capture
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r <= 8'h00;
        end else if (hreadyout_o) begin
            dp_valid_r <= hsel_i && htrans_i[1] && hready_i;
            dp_write_r <= hwrite_i;
            dp_addr_r <= haddr_i[7:0];
        end
    end

    assign dp_cmd = dp_valid_r && dp_write_r && dp_addr_r == CTRL_CMD_OFS;
    assign dp_dma = dp_valid_r && dp_write_r &&
                    (dp_addr_r == CTRL_DMA_OFS ||
                     dp_addr_r == CTRL_DMA_LAST_OFS);
    // Data phase of a link command stalls until the device answers
    assign launch = (dp_cmd || (dp_dma && link.dma_req)) && !launch_r;
    assign hold = (dp_cmd || dp_dma) && !(launch_r && link.ack && req_r);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            launch_r <= 1'b0;
            req_r <= 1'b0;
            we_r <= 1'b0;
            last_r <= 1'b0;
            addr_r <= 8'h00;
            lwdata_r <= HUC_RESET_VAL;
            rdata_r <= HUC_RESET_VAL;
        end else begin
            if (launch) begin
                launch_r <= 1'b1;
                req_r <= 1'b1;
                if (dp_cmd) begin
                    we_r <= hwdata_i[CMD_WRITE_B];
                    addr_r <= hwdata_i[7:0];
                    lwdata_r <= wdata_r;
                    last_r <= 1'b0;
                end else begin
                    we_r <= 1'b1;
                    addr_r <= HUC_DI_OFS;
                    lwdata_r <= hwdata_i;
                    last_r <= dp_addr_r == CTRL_DMA_LAST_OFS;
                end
            end else if (req_r && link.ack) begin
                req_r <= 1'b0;
                launch_r <= 1'b0;
                if (!we_r) begin
                    rdata_r <= link.rdata;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wdata_r <= HUC_RESET_VAL;
        end else if (hreadyout_o && dp_valid_r && dp_write_r &&
                     dp_addr_r == CTRL_WDATA_OFS) begin
            wdata_r <= hwdata_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_r <= HUC_RESET_VAL;
        end else if (hreadyout_o && hsel_i && htrans_i[1] && !hwrite_i) begin
            case (haddr_i[7:0])
                CTRL_WDATA_OFS: hrdata_r <= wdata_r;
                CTRL_RDATA_OFS: hrdata_r <= rdata_r;
                CTRL_STATUS_OFS: hrdata_r <= {29'h0, link.dma_req,
                                              link.irq, req_r};
                default: hrdata_r <= HUC_RESET_VAL;
            endcase
        end
    end

    assign hreadyout_o = !hold;
    assign hresp_o = 1'b0;
    assign hrdata_o = (!req_r && !launch_r && dp_valid_r && !dp_write_r &&
                       dp_addr_r == CTRL_RDATA_OFS) ? rdata_r : hrdata_r;
    assign irq_o = link.irq;
    assign link.req = req_r;
    assign link.we = we_r;
    assign link.addr = addr_r;
    assign link.wdata = lwdata_r;
    assign link.last = last_r;
endmodule : hucia_feeder

// *** verif/hucia_asserts.sv ***
// Concurrent checks on the link between hash unit and feeder
module hucia_asserts (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic last,
    input wire logic ack,
    input wire logic [31:0] rdata,
    input wire logic dma_req,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking dc @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_ack_one_cycle: assert property (ack |=> !ack)
        else $error("ack held longer than one cycle");
    chk_ack_has_cause: assert property (ack |->
        $past(req) && !$past(ack))
        else $error("ack without a pending request");
    chk_req_dropped: assert property (ack |=> !req)
        else $error("request not dropped after ack");
    chk_req_held: assert property (req && !ack |=>
        req && $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request changed before ack");
    chk_read_prompt: assert property ($rose(req) && !we |->
        ##[1:2] ack)
        else $error("read not answered promptly");
    // Writes may stall for a whole block run
    chk_write_bound: assert property ($rose(req) && we |->
        ##[1:100] ack)
        else $error("write not answered within a block run");
    chk_rdata_source: assert property ($changed(rdata) |->
        ack && !we)
        else $error("read data changed outside a read");
    chk_dma_last_stop: assert property (ack && we && last |->
        ##[0:2] !dma_req)
        else $error("dma request stays after last word");

    cover property (ack && we && last);
    cover property ($rose(irq));
    cover property (ack && !we && addr == 8'h24);
endmodule : hucia_asserts

// *** verif/hucia_tb_top.sv ***
// Testbench driving the feeder over AHB-Lite into the hash unit
module hucia_tb_top
    import hucia_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] ST = 32'h0000_0004;
    localparam logic [31:0] DMA_EN = 32'h0000_0008;
    localparam logic [31:0] PENDING = 32'h0000_1000;
    localparam logic [31:0] MULTI = 32'h0000_2000;
    localparam logic [31:0] W1 = 32'h1234_8001;
    localparam logic [31:0] W2 = 32'hA5C3_0F0F;
    logic ref_clk_i, rst_n_i, hsel, hwrite, busy, irq, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata, sum;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;

    hucia_if u_hucia_if ();
    hucia_device u_hucia_device (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .bus(u_hucia_if), .busy_o(busy), .digest_sum_o(sum));
    hucia_feeder u_hucia_feeder (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .link(u_hucia_if), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .irq_o(irq));
    hucia_asserts u_hucia_asserts (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .req(u_hucia_if.req), .we(u_hucia_if.we), .addr(u_hucia_if.addr),
        .wdata(u_hucia_if.wdata), .last(u_hucia_if.last),
        .ack(u_hucia_if.ack), .rdata(u_hucia_if.rdata),
        .dma_req(u_hucia_if.dma_req), .irq(u_hucia_if.irq));

    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic complete_run();
        if (fail_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Hready is looked at mid-cycle, where it is settled until the edge
    task automatic ahb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        logic ok;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do begin
            @(negedge ref_clk_i);
            ok = hready;
            @(posedge ref_clk_i);
        end while (ok !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(negedge ref_clk_i);
            ok = hready;
            q = hrdata;
            @(posedge ref_clk_i);
        end while (ok !== 1'b1);
    endtask : ahb

    task automatic dwr(input logic [7:0] o, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, CTRL_WDATA_OFS, d, q);
        ahb(1'b1, CTRL_CMD_OFS, {1'b1, 23'h00_0000, o}, q);
    endtask : dwr

    task automatic drd(input logic [7:0] o, output logic [31:0] q);
        ahb(1'b1, CTRL_CMD_OFS, {24'h00_0000, o}, q);
        ahb(1'b0, CTRL_RDATA_OFS, 32'h0000_0000, q);
    endtask : drd

    task automatic poll(input logic [31:0] m);
        logic [31:0] q;
        q = 32'h0000_0000;
        for (int i = 0; i < 200 && (q & m) == 0; i++)
            drd(HUC_STAT_OFS, q);
    endtask : poll

    task automatic irqchk(input logic e);
        @(negedge ref_clk_i);
        chk("irq", {31'h0000_0000, e}, {31'h0000_0000, irq});
        @(posedge ref_clk_i);
    endtask : irqchk

    function automatic logic [31:0] swp(input logic [31:0] w,
        input logic [1:0] m);
        logic [31:0] r;
        r = w;
        case (m)
            2'b01: r = {w[15:0], w[31:16]};
            2'b10: r = {w[7:0], w[15:8], w[23:16], w[31:24]};
            2'b11: for (int i = 0; i < 32; i++) r[i] = w[31-i];
            default: r = w;
        endcase
        return r;
    endfunction : swp

    task automatic t_reset();
        logic [31:0] q;
        drd(HUC_CTL_OFS, q);
        chk("ctl", HUC_RESET_VAL, q);
        drd(HUC_STAT_OFS, q);
        chk("stat", 32'h0000_0000, q);
        drd(8'h40, q);
        chk("unmapped", 32'h0000_0000, q);
        chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    endtask : t_reset

    task automatic t_algo();
        logic [31:0] e, q;
        for (int a = 0; a < 4; a++) begin
            e = (a[1] << 18) | (a[0] << 7) | (a[0] << 16) | (a[1] << 6);
            e = e | (a[0] << 13);
            dwr(HUC_CTL_OFS, e | ST);
            drd(HUC_CTL_OFS, q);
            chk("ctl", e, q);
        end
    endtask : t_algo

    task automatic t_swap();
        logic [31:0] q;
        for (int m = 0; m < 4; m++) begin
            dwr(HUC_CTL_OFS, (m << 4) | ST);
            dwr(HUC_DI_OFS, W1);
            dwr(HUC_DI_OFS, W2);
            drd(HUC_DI_OFS, q);
            chk("di", W2, q);
            drd(HUC_SUM_OFS, q);
            chk("sum", swp(W1, m[1:0]), q);
            chk("sum_o", swp(W1, m[1:0]), sum);
            drd(HUC_CTL_OFS, q);
            chk("ctl", (m << 4) | PENDING | 32'h0000_0100, q);
            dwr(HUC_CTL_OFS, (m << 4) | ST);
            drd(HUC_CTL_OFS, q);
            chk("ctl", m << 4, q);
        end
    endtask : t_swap

    task automatic t_block();
        logic [31:0] q;
        dwr(HUC_INTEN_OFS, 32'h0000_0001);
        dwr(HUC_CTL_OFS, ST);
        for (int i = 0; i < 17; i++)
            dwr(HUC_DI_OFS, 32'h0100_0000 + i);
        poll(32'h0000_0001);
        drd(HUC_STAT_OFS, q);
        chk("stat", 32'h0000_0001, q);
        chk("busy", 32'h0000_0000, {31'h0000_0000, busy});
        irqchk(1'b1);
        drd(HUC_CTL_OFS, q);
        chk("ctl", PENDING, q);
        chk("count", 32'h0000_0000, q & 32'h0000_0F00);
        dwr(HUC_INTEN_OFS, 32'h0000_0000);
        irqchk(1'b0);
        dwr(HUC_STAT_OFS, 32'h0000_0000);
    endtask : t_block

    task automatic t_final();
        logic [31:0] q;
        dwr(HUC_CFG_OFS, 32'h0000_0118);
        poll(32'h0000_0002);
        drd(HUC_CFG_OFS, q);
        chk("cfg", 32'h0000_0018, q);
        drd(HUC_CTL_OFS, q);
        chk("ctl", 32'h0000_0000, q);
        drd(HUC_STAT_OFS, q);
        chk("stat", 32'h0000_0002, q);
        dwr(HUC_INTEN_OFS, 32'h0000_0002);
        irqchk(1'b1);
        dwr(HUC_STAT_OFS, 32'h0000_0000);
        irqchk(1'b0);
    endtask : t_final

    task automatic t_dma();
        logic [31:0] q;
        dwr(HUC_CTL_OFS, ST);
        dwr(HUC_CTL_OFS, DMA_EN);
        ahb(1'b0, CTRL_STATUS_OFS, 32'h0000_0000, q);
        chk("dreq", 32'h0000_0004, q & 32'h0000_0004);
        dwr(HUC_CTL_OFS, 32'h0000_0000);
        ahb(1'b0, CTRL_STATUS_OFS, 32'h0000_0000, q);
        chk("dreq", 32'h0000_0004, q & 32'h0000_0004);
        ahb(1'b1, CTRL_DMA_OFS, W1, q);
        ahb(1'b1, CTRL_DMA_LAST_OFS, W2, q);
        drd(HUC_CTL_OFS, q);
        chk("dma_en", 32'h0000_0000, q & DMA_EN);
        poll(32'h0000_0002);
        drd(HUC_STAT_OFS, q);
        chk("stat", 32'h0000_0002, q);
        dwr(HUC_STAT_OFS, 32'h0000_0000);
        dwr(HUC_CTL_OFS, MULTI | DMA_EN);
        ahb(1'b1, CTRL_DMA_LAST_OFS, W1, q);
        drd(HUC_STAT_OFS, q);
        chk("stat", 32'h0000_0000, q);
        drd(HUC_CTL_OFS, q);
        chk("dma_en", 32'h0000_0000, q & DMA_EN);
        dwr(HUC_CTL_OFS, MULTI | DMA_EN);
        dwr(HUC_CTL_OFS, MULTI | DMA_EN | ST);
        drd(HUC_CTL_OFS, q);
        chk("ctl", MULTI | DMA_EN, q);
    endtask : t_dma

    initial begin
        rst_n_i = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_algo();
        t_swap();
        t_block();
        t_final();
        t_dma();
        complete_run();
    end
endmodule : hucia_tb_top
